// ==== pad_board.sv ====
// Purpose: board side of one 16-bit port pad
// Assumes: board holds a level on every pin the device lets go
// Notes: device driver wins over the board level
`timescale 1ns/1ps
`default_nettype none
module pad_board (
  // device side
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  // board side
  input wire logic [15:0] boardLevel,
  output logic [15:0] pinLevel
);
  assign pinLevel = (pinOut & pinOe) | (boardLevel & ~pinOe);
endmodule
`default_nettype wire

// ==== pin_function_reset_config.sv ====
// Purpose: pin-function routing, reset indication and trap/power-down qualification
// Assumes: all pin inputs synchronous to core_clk
// Notes: port pin drivers are out/enable pairs; the pad ring resolves the wire
`timescale 1ns/1ps
`default_nettype none
module pin_function_reset_config (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_in_n, // R4
  input wire logic softResetReq,
  input wire logic watchdogResetReq,
  input wire logic end_of_init_instr,
  // straps and configuration
  input wire logic bus_cfg_sel_lo,
  input wire logic bus_cfg_sel_hi,
  input wire logic segEnable,
  // software port settings
  input wire logic [15:0] p0Dir,
  input wire logic [15:0] p0Out,
  input wire logic [15:0] p1Dir,
  input wire logic [15:0] p1Out,
  input wire logic [15:0] p2Dir,
  input wire logic [15:0] p2Out,
  input wire logic [15:0] p3Dir,
  input wire logic [15:0] p3Out,
  input wire logic [1:0] p4Dir,
  input wire logic [1:0] p4Out,
  // external bus controller
  input wire logic [17:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busAddrPhase,
  input wire logic busDataDrive,
  input wire logic busReadReq,
  input wire logic busWriteReq,
  input wire logic busHighByte,
  // peripheral alternate outputs
  input wire logic [15:0] capcomOut,
  input wire logic [15:0] capcomOutEn,
  input wire logic timer_six_toggle_out,
  input wire logic timer_three_toggle_out,
  // pin inputs and power-down instruction
  input wire logic [15:0] p0In,
  input wire logic [15:0] p1In,
  input wire logic [15:0] p2In,
  input wire logic [15:0] p3In,
  input wire logic [1:0] p4In,
  input wire logic [9:0] p5In,
  input wire logic nmiIn_n,
  input wire logic power_down_instr,
  // pin drivers
  output logic [15:0] p0PinOut,
  output logic [15:0] p0PinOe,
  output logic [15:0] p1PinOut,
  output logic [15:0] p1PinOe,
  output logic [15:0] p2PinOut,
  output logic [15:0] p2PinOe,
  output logic [15:0] p3PinOut,
  output logic [15:0] p3PinOe,
  output logic [1:0] p4PinOut,
  output logic [1:0] p4PinOe,
  output logic addrLatchEn,
  output logic readStrobe_n,
  output logic reset_indication_n,
  // to core and peripherals
  output pin_mux_pkg::bus_mode_t busMode,
  output logic [15:0] p0Data,
  output logic [15:0] p1Data,
  output logic [15:0] p2Data,
  output logic [15:0] p3Data,
  output logic [1:0] p4Data,
  output logic [9:0] p5Data,
  output logic [9:0] analog_channel_n,
  output logic [15:0] capcomPinIn,
  output logic timer_zero_count_in,
  output logic capture_reload_in,
  output logic timer_three_updown_in,
  output logic timer_four_multi_in,
  output logic timer_three_count_in,
  output logic busReadyIn_n,
  output logic nmiTrapReq,
  output logic powerDownEnter
);
  import pin_mux_pkg::*;

  function automatic logic [15:0] gpOe(input logic rstHold, input logic [15:0] dir);
    gpOe = rstHold ? DIR_RESET : dir; // R2 R17
  endfunction

  logic resetActive;
  logic initDone;
  logic nmiPrev;
  logic clkHalf;

  wire anyReset = !reset_in_n || softResetReq || watchdogResetReq;
  wire extBus = busMode != MODE_SINGLE;
  wire muxBus = busMode == MODE_MUX8 || busMode == MODE_MUX16;

  strap_latch u_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .resetActive(resetActive),
    .bus_cfg_sel_lo(bus_cfg_sel_lo),
    .bus_cfg_sel_hi(bus_cfg_sel_hi),
    .busMode(busMode)
  );

  // reset indication holds until software signs off initialisation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetActive <= 1'b1;
      initDone <= 1'b0;
      reset_indication_n <= 1'b0;
    end else begin
      resetActive <= anyReset;
      if (anyReset) begin
        initDone <= 1'b0; // R5
      end else if (end_of_init_instr) begin
        initDone <= 1'b1; // R5
      end
      reset_indication_n <= !anyReset && (initDone || end_of_init_instr); // R5
    end
  end

  // port 0: address/data; the 8-bit mux mode keeps the high byte as address
  wire [15:0] p0AddrMask = (busMode == MODE_MUX8) ? MUX8_ADDR_ONLY : 16'h0000;
  wire [15:0] p0BusOut = busAddrPhase ? busAddr[15:0] :
    ((busWrData & ~p0AddrMask) | (busAddr[15:0] & p0AddrMask & {16{busMode == MODE_MUX8}}));
  wire [15:0] p0BusDataVal = (busMode == MODE_DEMUX16) ? busWrData : p0BusOut; // R15
  wire [15:0] p0BusOe = (busMode == MODE_DEMUX16) ? {16{busDataDrive}} :
    (busAddrPhase ? 16'hFFFF :
     ({16{busDataDrive}} | ((busMode == MODE_MUX8) ? MUX8_ADDR_ONLY : 16'h0000))); // R15
  // port 1: address in demultiplexed mode only
  wire p1Claim = busMode == MODE_DEMUX16; // R10
  // port 4: segment address when segmentation is on in an external bus mode
  wire p4Claim = extBus && segEnable; // R3
  // port 3 alternate outputs merge into the software value
  logic [15:0] p3AltOut;
  logic [15:0] p3AltOe;
  always_comb begin
    p3AltOut = p3Out;
    p3AltOe = 16'h0000;
    p3AltOut[BIT_T6_OUT] = timer_six_toggle_out; // R13
    p3AltOut[BIT_T3_OUT] = timer_three_toggle_out; // R13
    p3AltOut[BIT_SYS_CLOCK_OUT] = clkHalf; // R16
    p3AltOe[BIT_SYS_CLOCK_OUT] = 1'b1; // R16
    if (extBus) begin
      p3AltOut[BIT_BHE] = !busHighByte; // R16
      p3AltOut[BIT_WR] = !busWriteReq; // R16
      p3AltOe = p3AltOe | (P3_BUS_OUT_MASK & ~(16'h1 << BIT_SYS_CLOCK_OUT)); // R18
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0PinOut <= OUT_RESET;
      p0PinOe <= DIR_RESET;
      p1PinOut <= OUT_RESET;
      p1PinOe <= DIR_RESET;
      p2PinOut <= OUT_RESET;
      p2PinOe <= DIR_RESET;
      p3PinOut <= OUT_RESET;
      p3PinOe <= DIR_RESET;
      p4PinOut <= 2'b00;
      p4PinOe <= 2'b00;
      addrLatchEn <= 1'b0;
      readStrobe_n <= 1'b1;
      clkHalf <= 1'b0;
    end else begin
      clkHalf <= !clkHalf; // R16
      p0PinOut <= extBus ? p0BusDataVal : p0Out; // R18
      p0PinOe <= resetActive ? DIR_RESET : (extBus ? p0BusOe : p0Dir); // R17 R18
      p1PinOut <= p1Claim ? busAddr[15:0] : p1Out; // R10
      p1PinOe <= resetActive ? DIR_RESET : (p1Claim ? 16'hFFFF : p1Dir); // R10 R17
      p2PinOut <= (p2Out & ~capcomOutEn) | (capcomOut & capcomOutEn); // R12
      p2PinOe <= gpOe(resetActive, p2Dir | capcomOutEn); // R12
      p3PinOut <= p3AltOut; // R13 R16
      p3PinOe <= resetActive ? DIR_RESET : (p3Dir | p3AltOe); // R17
      p4PinOut <= p4Claim ? busAddr[17:16] : p4Out; // R3
      p4PinOe <= resetActive ? 2'b00 : (p4Claim ? 2'b11 : p4Dir); // R3 R17
      addrLatchEn <= !resetActive && muxBus && busAddrPhase; // R8
      readStrobe_n <= !(!resetActive && extBus && busReadReq); // R9
    end
  end

  // input side: port data and alternate inputs, registered once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0Data <= 16'h0000;
      p1Data <= 16'h0000;
      p2Data <= 16'h0000;
      p3Data <= 16'h0000;
      p4Data <= 2'b00;
      p5Data <= 10'h000;
      analog_channel_n <= 10'h000;
      capcomPinIn <= 16'h0000;
      timer_zero_count_in <= 1'b0;
      capture_reload_in <= 1'b0;
      timer_three_updown_in <= 1'b0;
      timer_four_multi_in <= 1'b0;
      timer_three_count_in <= 1'b0;
      busReadyIn_n <= 1'b1;
      nmiPrev <= 1'b1;
      nmiTrapReq <= 1'b0;
      powerDownEnter <= 1'b0;
    end else begin
      p0Data <= p0In;
      p1Data <= p1In;
      p2Data <= p2In;
      p3Data <= p3In;
      p4Data <= p4In;
      p5Data <= p5In; // R11
      analog_channel_n <= p5In; // R11
      capcomPinIn <= p2In; // R12
      timer_zero_count_in <= p3In[BIT_T0_IN]; // R13
      capture_reload_in <= p3In[BIT_CAP_IN]; // R13
      timer_three_updown_in <= p3In[BIT_T3_UD]; // R14
      timer_four_multi_in <= p3In[BIT_T4_IN]; // R14
      timer_three_count_in <= p3In[BIT_T3_IN]; // R14
      busReadyIn_n <= p3In[BIT_RDY]; // R16
      nmiPrev <= nmiIn_n;
      nmiTrapReq <= nmiPrev && !nmiIn_n && !resetActive; // R6
      // a high interrupt pin vetoes power-down and the core keeps running
      powerDownEnter <= power_down_instr && !nmiIn_n && !resetActive; // R7
    end
  end
endmodule
`default_nettype wire

// ==== pin_function_reset_config_assertions.sv ====
// Purpose: port-level checks for the pin function block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pin_function_reset_config_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // stimulus seen by the block
  input wire logic nmiIn_n,
  input wire logic power_down_instr,
  input wire logic busReadReq,
  input wire logic busAddrPhase,
  input wire logic end_of_init_instr,
  input wire logic [17:0] busAddr,
  // block outputs
  input wire logic [1:0] busMode,
  input wire logic nmiTrapReq,
  input wire logic powerDownEnter,
  input wire logic readStrobe_n,
  input wire logic addrLatchEn,
  input wire logic reset_indication_n,
  input wire logic [15:0] p0PinOut,
  input wire logic [15:0] p1PinOut,
  input wire logic [15:0] p1PinOe
);
  import pin_mux_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_release_quiet: assert property ($rose(rst_n) |-> p1PinOe == 16'h0000 && !reset_indication_n)
    else $error("drivers or reset indication active at release");
  a_init_hold: assert property (!reset_indication_n && !end_of_init_instr |=> !reset_indication_n)
    else $error("reset indication left low state early");
  a_nmi_trap: assert property ($fell(nmiIn_n) && $past(rst_n, 2) |-> ##[1:2] nmiTrapReq)
    else $error("no trap after interrupt fall");
  a_pd_refused: assert property (nmiIn_n || !power_down_instr |=> !powerDownEnter)
    else $error("power-down entered without cause");
  a_pd_enter: assert property (power_down_instr && !nmiIn_n && $past(rst_n) |=> powerDownEnter)
    else $error("power-down not entered");
  a_read_strobe: assert property (busReadReq && busMode != MODE_SINGLE && $past(rst_n)
    |=> !readStrobe_n)
    else $error("read strobe missing");
  a_addr_latch: assert property (busAddrPhase && (busMode == MODE_MUX8 || busMode == MODE_MUX16)
    && $past(rst_n) |=> addrLatchEn && p0PinOut == $past(busAddr[15:0]))
    else $error("address phase not on port zero");
  a_demux_addr: assert property (busMode == MODE_DEMUX16 && $past(rst_n)
    |=> p1PinOut == $past(busAddr[15:0]) && p1PinOe == 16'hFFFF)
    else $error("port one not carrying address");
endmodule
bind pin_function_reset_config pin_function_reset_config_assertions i_chk (.*);
`default_nettype wire

// ==== pin_function_reset_config_test.sv ====
// Purpose: self-checking bench for the pin function block
// Assumes: 10 MHz clock, straps held through reset
// Notes: port 0 to 3 pin levels resolved by pad_board
`timescale 1ns/1ps
`default_nettype none
module pin_function_reset_config_test;
  import pin_mux_pkg::*;
  logic core_clk = 0, rst_n = 0, reset_in_n = 0, softResetReq = 0, watchdogResetReq = 0;
  logic end_of_init_instr = 0, bus_cfg_sel_lo = 0, bus_cfg_sel_hi = 0, segEnable = 0;
  logic busAddrPhase = 0, busDataDrive = 0, busReadReq = 0, busWriteReq = 0, busHighByte = 0;
  logic timer_six_toggle_out = 0, timer_three_toggle_out = 0, nmiIn_n = 1, power_down_instr = 0;
  logic [15:0] p0Dir = 0, p0Out = 0, p1Dir = 0, p1Out = 0, p2Dir = 0, p2Out = 0, p3Dir = 0;
  logic [15:0] p3Out = 0, busWrData = 0, capcomOut = 0, capcomOutEn = 0, b1 = 0, b2 = 0, b3 = 0;
  logic [15:0] p0In, p1In, p2In, p3In, p0Data, p1Data, p2Data, p3Data, capcomPinIn;
  logic [15:0] p0PinOut, p0PinOe, p1PinOut, p1PinOe, p2PinOut, p2PinOe, p3PinOut, p3PinOe;
  logic [17:0] busAddr = 0, hits;
  logic [1:0] p4Dir = 0, p4Out = 0, p4PinOut, p4PinOe, p4Data;
  logic [9:0] p5In = 0, p5Data, analog_channel_n;
  logic addrLatchEn, readStrobe_n, reset_indication_n, timer_zero_count_in, capture_reload_in;
  logic timer_three_updown_in, timer_four_multi_in, timer_three_count_in, busReadyIn_n;
  logic nmiTrapReq, powerDownEnter;
  bus_mode_t busMode;
  int err_total = 0, compares = 0;
  // undriven segment pins read low, as with a board pull-down
  wire [1:0] p4In = p4PinOut & p4PinOe;
  pin_function_reset_config i_dut (.*);
  pad_board i_pad0 (.pinOut(p0PinOut), .pinOe(p0PinOe), .boardLevel(16'h0000), .pinLevel(p0In));
  pad_board i_pad1 (.pinOut(p1PinOut), .pinOe(p1PinOe), .boardLevel(b1), .pinLevel(p1In));
  pad_board i_pad2 (.pinOut(p2PinOut), .pinOe(p2PinOe), .boardLevel(b2), .pinLevel(p2In));
  pad_board i_pad3 (.pinOut(p3PinOut), .pinOe(p3PinOe), .boardLevel(b3), .pinLevel(p3In));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge core_clk);
    rst_n <= 0;
    reset_in_n <= 0;
    {bus_cfg_sel_hi, bus_cfg_sel_lo} <= m;
    tick(10);
    chk("oeInReset", 18'h0, p0PinOe | p1PinOe | p2PinOe | p3PinOe | p4PinOe);
    @(posedge core_clk);
    rst_n <= 1;
    reset_in_n <= 1;
    // straps must still stand at the first edge after release, where the latch closes
    tick(3);
    chk("busMode", m, busMode);
    chk("indHold", 18'h0, reset_indication_n);
    @(posedge core_clk);
    end_of_init_instr <= 1;
    {bus_cfg_sel_hi, bus_cfg_sel_lo} <= ~m;
    @(posedge core_clk);
    end_of_init_instr <= 0;
    tick(1);
    chk("indEoi", 18'h1, reset_indication_n);
    chk("busFrozen", m, busMode);
  endtask
  task automatic t_single;
    do_reset(2'h0);
    @(posedge core_clk);
    {p0Dir, p0Out, p1Dir, p1Out} <= 64'h0F0F_00FF_00F0_A5A5;
    {p2Dir, p2Out, p3Dir, p3Out} <= 64'h0100_0100_000A_0008;
    {p4Dir, p4Out, timer_three_toggle_out, timer_six_toggle_out} <= 6'h37;
    {b1, b2, b3, capcomOut, capcomOutEn} <= 80'h1234_C3A4_0035_0001_0001;
    p5In <= 10'h2A5;
    tick(3);
    chk("p1PinOe", 18'h00F0, p1PinOe);
    chk("p1Data", 18'h12A4, p1Data);
    chk("p4PinOe", 18'h3, p4PinOe);
    chk("analog", 18'h2A5, analog_channel_n);
    chk("timerIns", 18'hF, {timer_three_count_in, timer_four_multi_in,
      timer_three_updown_in, capture_reload_in, timer_zero_count_in});
    chk("capcomOe", 18'h0101, p2PinOe);
    chk("capcomIn", 18'hC3A5, capcomPinIn);
    chk("p2Data", 18'hC3A5, p2Data);
    chk("p0Data", 18'h000F, p0Data);
    chk("p4Data", 18'h1, p4Data);
    chk("p5Data", 18'h2A5, p5Data);
    chk("p3Data", 18'h3F, p3Data[6:0]);
    chk("p3PinOe", 18'h800A, p3PinOe);
    chk("ready", 18'h0, busReadyIn_n);
    hits = p3PinOut[15];
    tick(1);
    chk("sys_clock_out", !hits[0], p3PinOut[15]);
  endtask
  task automatic t_ext(input logic [1:0] m);
    do_reset(m);
    @(posedge core_clk);
    {segEnable, busAddrPhase, busReadReq, busHighByte} <= 4'hF;
    p1Dir <= 16'h0000;
    busAddr <= 18'h2_5A3C;
    tick(2);
    chk("readStrobe_n", 18'h0, readStrobe_n);
    chk("segAddr", 18'h2, p4PinOut);
    if (m == 2'h3) chk("p1Addr", 18'h5A3C, p1PinOut);
    else chk("aleP0", 18'h1_5A3C, {addrLatchEn, p0PinOut});
    chk("busStrobes", 18'h2B, {p3PinOut[13:12], p3PinOe[15:12]});
    @(posedge core_clk);
    {segEnable, busAddrPhase, busReadReq, busWriteReq, busDataDrive} <= 5'h3;
    busWrData <= 16'h7E81;
    tick(2);
    if (m == 2'h1) chk("p0Mux8", 18'h5A81, p0PinOut);
    if (m != 2'h1) chk("p0Word", 18'h7E81, p0PinOut);
    chk("p0Oe", 18'hFFFF, p0PinOe);
    chk("wrStrobe", 18'h0B, {p3PinOut[13:12], p3PinOe[15:12]});
    chk("segOff", 18'h1, p4PinOut);
    @(posedge core_clk);
    {busWriteReq, busDataDrive} <= 2'h0;
  endtask
  task automatic count_pd(input logic lvl);
    @(posedge core_clk);
    nmiIn_n <= lvl;
    power_down_instr <= 1;
    @(posedge core_clk);
    power_down_instr <= 0;
    hits = 0;
    // both pulses stand only in the cycle right after the sampling edge
    repeat (3) begin
      #1;
      hits += {powerDownEnter, nmiTrapReq};
      @(posedge core_clk);
    end
  endtask
  task automatic t_nmi_pd;
    count_pd(1'h1);
    chk("pdRefused", 18'h0, hits);
    count_pd(1'h0);
    chk("pdAndTrap", 18'h3, hits);
  endtask
  task automatic t_soft_reset;
    @(posedge core_clk);
    softResetReq <= 1;
    @(posedge core_clk);
    softResetReq <= 0;
    watchdogResetReq <= 1;
    tick(2);
    chk("swReset", 18'h0, {reset_indication_n, p2PinOe | p3PinOe});
    @(posedge core_clk);
    watchdogResetReq <= 0;
    tick(2);
    chk("swMode", 18'h1, busMode);
    @(posedge core_clk);
    end_of_init_instr <= 1;
    @(posedge core_clk);
    end_of_init_instr <= 0;
    tick(1);
    chk("swEoi", 18'h1_0101, {reset_indication_n, p2PinOe});
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_single;
    t_ext(2'h1);
    t_ext(2'h3);
    t_ext(2'h2);
    t_nmi_pd;
    t_soft_reset;
    report_and_stop;
  end
  // about 120 cycles of tests; 2000 cycles means a hang
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ==== pin_mux_pkg.sv ====
// Purpose: constants and types for the pin-function and reset-configuration block
// Assumes: one 10 MHz core clock, asynchronous active-low reset
// Notes: bus modes follow the two configuration straps
// Functional notes
// R1: straps sampled during reset pick single chip, mux 8-bit, mux 16-bit, demux 16-bit
// R2: every bidirectional pin has its own direction bit; input means driver off
// R3: segment port bit 0 low segment address, bit 1 high, when segmentation on; code also requires an external bus mode
// R4: board holds reset input low long enough; pull-up allows capacitor power-on reset
// R5: reset indication low during any reset until end-of-init instruction executes
// R6: falling edge on the interrupt input raises a trap request to the processor
// R7: power-down entered only when interrupt input low at power-down instruction
// R8: address latch enable output is driven in the multiplexed bus modes
// R9: read strobe asserted low for every external instruction or data read
// R10: port one outputs address 0..15 in non-multiplexed mode, else general port
// R11: port five is ten input-only pins, each also an analog channel
// R12: port two pin n is capture input or compare output of channel n
// R13: port three bits 0..3 carry timer zero in, six out, capture in, three out
// R14: port three bits 4..6 carry timer three updown, timer four, timer three inputs
// R15: port zero multiplexes address and data, low byte only in 8-bit mode
// R16: port three bit 15 outputs half-rate clock; bits 12..14 byte enable, write, ready
// R17: during reset every bidirectional pin is an input with driver off
// R18: pins claimed by the active bus mode override general direction and output; code leaves the ready pin (port three bit 14) under p3Dir
package pin_mux_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MUX8 = 2'b01,
    MODE_MUX16 = 2'b10,
    MODE_DEMUX16 = 2'b11
  } bus_mode_t;
  localparam int PORT_W = 16;
  localparam int SEG_W = 2;
  localparam int ANA_W = 10;
  localparam int BIT_SEG_LO = 0;
  localparam int BIT_SEG_HI = 1;
  localparam int BIT_T0_IN = 0;
  localparam int BIT_T6_OUT = 1;
  localparam int BIT_CAP_IN = 2;
  localparam int BIT_T3_OUT = 3;
  localparam int BIT_T3_UD = 4;
  localparam int BIT_T4_IN = 5;
  localparam int BIT_T3_IN = 6;
  localparam int BIT_BHE = 12;
  localparam int BIT_WR = 13;
  localparam int BIT_RDY = 14;
  localparam int BIT_SYS_CLOCK_OUT = 15;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] OUT_RESET = 16'h0000;
  localparam logic [15:0] MUX8_ADDR_ONLY = 16'hFF00;
  localparam logic [15:0] P3_BUS_OUT_MASK = 16'hB000;
endpackage

// ==== strap_latch.sv ====
// Purpose: capture bus configuration straps while reset is held
// Assumes: straps are stable during reset
// Notes: latch closes on the first edge after reset release
`timescale 1ns/1ps
`default_nettype none
module strap_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic resetActive,
  // straps
  input wire logic bus_cfg_sel_lo,
  input wire logic bus_cfg_sel_hi,
  // latched mode
  output pin_mux_pkg::bus_mode_t busMode
);
  import pin_mux_pkg::*;
  // asynchronous reset loads a constant; straps follow while reset is held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busMode <= MODE_SINGLE;
    end else if (resetActive) begin
      busMode <= bus_mode_t'({bus_cfg_sel_hi, bus_cfg_sel_lo}); // R1
    end
  end
endmodule
`default_nettype wire
